/* logic/pwrt_top.sv */
// Periodic wakeup and reset timer with an APB register port.
// Assumes the tick, thermal and warm reset inputs are asynchronous pins.
`timescale 1ns/1ps

module pwrt_top (
  // Clock and power-on reset.
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // Asynchronous pins.
  input  wire logic        LFO_TICK,
  input  wire logic        THERMAL_OUT_OF_RANGE,
  input  wire logic        WARM_RESET,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Core side.
  output logic             WAKE_INTERRUPT,
  output logic             CORE_RESET,
  output logic             IRQ
);

  // -----------------------------------------------------------------
  // State and working signals.
  // -----------------------------------------------------------------
  pwrt_pkg::pwrt_state_t st_ff;     // Registered state.
  pwrt_pkg::pwrt_state_t nxt_st;    // Next state.
  logic                  tick;      // One-cycle oscillator tick.
  logic                  oor;       // Synchronised out-of-range level.
  logic                  warm;      // Synchronised warm reset.
  logic [10:0]           div_last;  // Last prescaler count.
  logic                  wclk;      // Wake clock pulse.
  logic                  wake_hit;  // Wake counter match.
  logic                  rst_hit;   // Reset counter match.
  logic                  blocked;   // Thermal block active.
  logic                  wake_out;  // Wake interrupt issued.
  logic                  rst_out;   // Periodic reset issued.
  logic                  setup;     // APB setup phase.
  logic                  wr_acc;    // APB write completes this edge.
  logic [7:0]            idx;       // Register index of the address.
  logic                  mapped;    // Address hits a register.
  logic [5:0]            wdat;      // Written six-bit field.
  logic [31:0]           rd;        // Read data being assembled.
  logic [pwrt_pkg::NEVT-1:0] evt_set; // Events of this cycle.

  // -----------------------------------------------------------------
  // Combinational next state.
  // -----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // The first stage of each synchroniser feeds only the second.
    nxt_st.tick_sync = {st_ff.tick_sync[1:0], LFO_TICK};
    nxt_st.oor_sync  = {st_ff.oor_sync[0], THERMAL_OUT_OF_RANGE};
    nxt_st.srst_sync = {st_ff.srst_sync[0], WARM_RESET};
    tick = st_ff.tick_sync[1] & ~st_ff.tick_sync[2];
    oor  = st_ff.oor_sync[1];
    warm = st_ff.srst_sync[1];

    // Prescaler: no control bit stops it, so it always runs.
    div_last = pwrt_pkg::DIV_BASE + 11'({st_ff.prescale, 4'h0}) - 11'h001;
    wclk     = tick && (st_ff.pre_cnt == div_last);
    if (tick) begin
      if (wclk) begin
        nxt_st.pre_cnt = 11'h000;
      end else begin
        nxt_st.pre_cnt = st_ff.pre_cnt + 11'h001;
      end
    end

    // Wake counter counts wake clocks up to the interval.
    wake_hit = 1'b0;
    if (wclk) begin
      if (st_ff.wake_ivl != pwrt_pkg::ZERO6 && st_ff.wake_cnt + 6'h01 == st_ff.wake_ivl) begin
        wake_hit        = 1'b1;
        nxt_st.wake_cnt = 6'h00;
      end else begin
        nxt_st.wake_cnt = st_ff.wake_cnt + 6'h01;
      end
    end

    // Reset counter is clocked by the wake period.
    rst_hit = 1'b0;
    if (wake_hit) begin
      if (st_ff.rst_ivl != pwrt_pkg::ZERO6 && st_ff.rst_cnt + 6'h01 == st_ff.rst_ivl) begin
        rst_hit        = 1'b1;
        nxt_st.rst_cnt = 6'h00;
      end else begin
        nxt_st.rst_cnt = st_ff.rst_cnt + 6'h01;
      end
    end

    // Thermal block gates outputs only; counters above keep going.
    blocked  = st_ff.thermal_restart_enable & oor;
    rst_out  = rst_hit & ~blocked;
    // A reset in the same cycle wins over the interrupt.
    wake_out = wake_hit & ~rst_hit & ~blocked;
    nxt_st.core_rst = rst_out;

    // APB decode.
    setup  = PSEL & ~PENABLE;
    wr_acc = PSEL & PENABLE & st_ff.pready & PWRITE;
    idx    = PADDR[9:2];
    wdat   = PWDATA[5:0];
    mapped = (PADDR[31:10] == 22'h000000) && (PADDR[1:0] == 2'b00) &&
             (idx >= pwrt_pkg::IDX_PRESCALE) && (idx <= pwrt_pkg::IDX_EVT_EN);

    // Register writes; a write takes effect at the completing edge.
    if (wr_acc && mapped) begin
      if (idx == pwrt_pkg::IDX_PRESCALE) begin
        // Upper two bits are not stored.
        nxt_st.prescale = wdat;
      end else if (idx == pwrt_pkg::IDX_WAKE) begin
        if (wdat == pwrt_pkg::ZERO6) begin
          // Zeroing is refused while the reset interval is zero.
          if (st_ff.rst_ivl != pwrt_pkg::ZERO6 && st_ff.wake_ivl != pwrt_pkg::ZERO6) begin
            nxt_st.wake_ivl = pwrt_pkg::ZERO6;
            nxt_st.wake_cnt = pwrt_pkg::WAKE_CNT_OFF;
          end
        end else if (wdat != st_ff.wake_ivl) begin
          // A new interval restarts the period; a rewrite is ignored.
          nxt_st.wake_ivl = wdat;
          nxt_st.wake_cnt = 6'h00;
          nxt_st.pre_cnt  = 11'h000;
        end
      end else if (idx == pwrt_pkg::IDX_RESET) begin
        // Same guard the other way round.
        if (wdat != pwrt_pkg::ZERO6 || st_ff.wake_ivl != pwrt_pkg::ZERO6) begin
          if (wdat != st_ff.rst_ivl) begin
            nxt_st.rst_ivl = wdat;
            nxt_st.rst_cnt = 6'h00;
          end
        end
      end else if (idx == pwrt_pkg::IDX_STATUS) begin
        nxt_st.sel_rst = PWDATA[0];
      end else if (idx == pwrt_pkg::IDX_THERMAL) begin
        nxt_st.thermal_restart_enable = PWDATA[0];
      end else if (idx == pwrt_pkg::IDX_EVT_EN) begin
        nxt_st.evt_en = PWDATA[pwrt_pkg::NEVT-1:0];
      end
    end

    // Wake flag: set wins over an acknowledge in the same cycle.
    if (wr_acc && mapped && idx == pwrt_pkg::IDX_WAKE && PWDATA[pwrt_pkg::WAKE_ACK_BIT]) begin
      nxt_st.wake_flag = 1'b0;
    end
    if (wake_out) begin
      nxt_st.wake_flag = 1'b1;
    end

    // Sticky events: write one to clear, new event wins.
    evt_set = '0;
    evt_set[pwrt_pkg::EVT_WAKE]    = wake_out;
    evt_set[pwrt_pkg::EVT_RESET]   = rst_out;
    evt_set[pwrt_pkg::EVT_BLOCKED] = blocked & (wake_hit | rst_hit);
    if (wr_acc && mapped && idx == pwrt_pkg::IDX_EVT_CLR) begin
      nxt_st.evt = st_ff.evt & ~PWDATA[pwrt_pkg::NEVT-1:0];
    end
    nxt_st.evt = nxt_st.evt | evt_set;
    nxt_st.irq = |(nxt_st.evt & nxt_st.evt_en);

    // Read data is captured in the setup cycle, answered next cycle.
    rd = 32'h00000000;
    if (idx == pwrt_pkg::IDX_PRESCALE) begin
      rd[5:0] = st_ff.prescale;
    end else if (idx == pwrt_pkg::IDX_WAKE) begin
      // Acknowledge bit always reads zero.
      rd[pwrt_pkg::WAKE_FLAG_BIT] = st_ff.wake_flag;
      rd[5:0] = st_ff.wake_ivl;
    end else if (idx == pwrt_pkg::IDX_RESET) begin
      rd[5:0] = st_ff.rst_ivl;
    end else if (idx == pwrt_pkg::IDX_STATUS) begin
      rd[0] = st_ff.sel_rst;
      // Select bit picks which counter software sees.
      rd[pwrt_pkg::CNT_LSB +: 6] = st_ff.sel_rst ? st_ff.rst_cnt : st_ff.wake_cnt;
    end else if (idx == pwrt_pkg::IDX_THERMAL) begin
      rd[0] = st_ff.thermal_restart_enable;
      rd[1] = oor;
    end else if (idx == pwrt_pkg::IDX_EVT) begin
      rd[pwrt_pkg::NEVT-1:0] = st_ff.evt;
    end else if (idx == pwrt_pkg::IDX_EVT_EN) begin
      rd[pwrt_pkg::NEVT-1:0] = st_ff.evt_en;
    end
    nxt_st.pready = setup;
    if (setup) begin
      nxt_st.prdata  = (mapped && !PWRITE) ? rd : 32'h00000000;
      nxt_st.pslverr = ~mapped;
    end else begin
      nxt_st.pslverr = 1'b0;
    end

    // Warm reset returns all timer and event state to its reset values, except the prescale value; synchronisers and APB outputs keep going.
    if (warm) begin
      nxt_st.pre_cnt   = 11'h000;
      nxt_st.wake_ivl  = pwrt_pkg::INTERVAL_RST;
      nxt_st.rst_ivl   = pwrt_pkg::INTERVAL_RST;
      nxt_st.wake_cnt  = 6'h00;
      nxt_st.rst_cnt   = 6'h00;
      nxt_st.sel_rst   = 1'b0;
      nxt_st.thermal_restart_enable       = 1'b0;
      nxt_st.wake_flag = 1'b0;
      nxt_st.core_rst  = 1'b0;
      nxt_st.evt       = '0;
      nxt_st.evt_en    = '0;
      nxt_st.irq       = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // State register; only power-on reset loads the prescale value.
  // -----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      st_ff          <= '0;
      st_ff.prescale <= pwrt_pkg::PRESCALE_POR;
      st_ff.wake_ivl <= pwrt_pkg::INTERVAL_RST;
      st_ff.rst_ivl  <= pwrt_pkg::INTERVAL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -----------------------------------------------------------------
  // Outputs straight from the state register.
  // -----------------------------------------------------------------
  // The wake output is not masked by the event enables; the thermal block and a periodic reset in the same cycle gate it.
  assign WAKE_INTERRUPT = st_ff.wake_flag;
  assign CORE_RESET     = st_ff.core_rst;
  assign IRQ            = st_ff.irq;
  assign PREADY         = st_ff.pready;
  assign PRDATA         = st_ff.prdata;
  assign PSLVERR        = st_ff.pslverr;

endmodule : pwrt_top

/* shared/pwrt_pkg.sv */
// Constants and types for the periodic wakeup and reset timer.
// Assumes one 200 MHz clock and an APB master with 32-bit data.
package pwrt_pkg;

  // -----------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // -----------------------------------------------------------------
  localparam logic [7:0] IDX_PRESCALE = 8'h38; // Wake prescale register.
  localparam logic [7:0] IDX_WAKE     = 8'h39; // Wake interval register.
  localparam logic [7:0] IDX_RESET    = 8'h3A; // Reset interval register.
  localparam logic [7:0] IDX_STATUS   = 8'h3B; // Timer status register.
  localparam logic [7:0] IDX_THERMAL  = 8'h3C; // Thermal restart control.
  localparam logic [7:0] IDX_EVT      = 8'h3D; // Sticky event status.
  localparam logic [7:0] IDX_EVT_CLR  = 8'h3E; // Event clear, write only.
  localparam logic [7:0] IDX_EVT_EN   = 8'h3F; // Event enable.

  // -----------------------------------------------------------------
  // Field positions and reset values.
  // -----------------------------------------------------------------
  localparam int         WAKE_FLAG_BIT = 7;     // Wake flag in wake reg.
  localparam int         WAKE_ACK_BIT  = 6;     // Acknowledge bit.
  localparam int         CNT_LSB       = 8;     // Counter field in status.
  localparam logic [5:0] PRESCALE_POR  = 6'h1F; // Nominal one second.
  localparam logic [5:0] INTERVAL_RST  = 6'h3F; // Interval after reset.
  localparam logic [5:0] WAKE_CNT_OFF  = 6'h3F; // Counter preset on disable.
  localparam logic [5:0] ZERO6         = 6'h00; // All-zero interval.
  localparam logic [10:0] DIV_BASE     = 11'h1F8; // 504 ticks.
  localparam int         DIV_STEP_SH   = 4;     // Step of 16 ticks.
  localparam int         NEVT          = 3;     // Event bits.
  localparam int         EVT_WAKE      = 0;     // Wake interrupt issued.
  localparam int         EVT_RESET     = 1;     // Periodic reset issued.
  localparam int         EVT_BLOCKED   = 2;     // Event blocked by thermal.

  // -----------------------------------------------------------------
  // Whole state of the block, registered once per clock.
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]      tick_sync;  // Tick synchroniser and edge history.
    logic [1:0]      oor_sync;   // Thermal out-of-range synchroniser.
    logic [1:0]      srst_sync;  // Warm reset synchroniser.
    logic [5:0]      prescale;   // Prescale value.
    logic [10:0]     pre_cnt;    // Prescaler tick count.
    logic [5:0]      wake_ivl;   // Wake interval field.
    logic [5:0]      rst_ivl;    // Reset interval field.
    logic [5:0]      wake_cnt;   // Wake counter.
    logic [5:0]      rst_cnt;    // Reset counter.
    logic            sel_rst;    // Status select: 1 shows reset counter.
    logic            thermal_restart_enable;        // Thermal restart enable.
    logic            wake_flag;  // Wake interrupt flag.
    logic            core_rst;   // Periodic reset pulse.
    logic [NEVT-1:0] evt;        // Sticky events.
    logic [NEVT-1:0] evt_en;     // Event enables.
    logic            irq;        // Summary interrupt.
    logic            pready;     // APB ready.
    logic            pslverr;    // APB error.
    logic [31:0]     prdata;     // APB read data.
  } pwrt_state_t;

endpackage : pwrt_pkg

/* testbench/pwrt_chk.sv */
// Port checks for the periodic wake and reset timer, bound to its top.
// Assumes byte addresses on APB and a single clock domain.
`timescale 1ns/1ps
module pwrt_chk (
  // Clock and resets.
  input wire logic        CLOCK,
  input wire logic        RESET,
  input wire logic        WARM_RESET,
  // Pins and APB.
  input wire logic        THERMAL_OUT_OF_RANGE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  // Core side.
  input wire logic        WAKE_INTERRUPT,
  input wire logic        CORE_RESET
);
  logic       wr_done;   // A write completes at this edge.
  logic       tre_sh;    // Shadow of the thermal enable bit.
  logic [2:0] blk_cnt;   // Cycles blocked, saturating at seven.
  logic [3:0] since_clr; // Cycles since an ack write or a warm reset.
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  // Helper state; the blocked count waits out the pin synchronisers.
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      tre_sh    <= 1'b0;
      blk_cnt   <= 3'h0;
      since_clr <= 4'h0;
    end else begin
      tre_sh    <= WARM_RESET ? 1'b0 : ((wr_done && PADDR == 32'hF0) ? PWDATA[0] : tre_sh);
      blk_cnt   <= !(tre_sh && THERMAL_OUT_OF_RANGE) ? 3'h0 : blk_cnt + {2'h0, blk_cnt != 3'h7};
      since_clr <= (WARM_RESET || (wr_done && PADDR == 32'hE4 && PWDATA[6])) ? 4'h0
                 : since_clr + {3'h0, since_clr != 4'hF};
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_prescale_top_zero: assert property
    (PREADY && !PWRITE && PADDR == 32'hE0 |-> PRDATA[31:6] == 26'h0) else $error("prescale top bits set");
  a_reset_one_cycle: assert property (CORE_RESET |=> !CORE_RESET) else $error("reset pulse too long");
  a_reset_wins: assert property (CORE_RESET |-> !$rose(WAKE_INTERRUPT)) else $error("wake beside reset");
  a_thermal_block: assert property (blk_cnt == 3'h7 |-> !CORE_RESET && !$rose(WAKE_INTERRUPT))
    else $error("event while blocked");
  a_ack_clears: assert property ($fell(WAKE_INTERRUPT) |-> since_clr < 4'h6)
    else $error("wake flag fell unasked");
endmodule : pwrt_chk

bind pwrt_top pwrt_chk pwrt_chk_inst (.CLOCK, .RESET, .WARM_RESET, .THERMAL_OUT_OF_RANGE, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .WAKE_INTERRUPT, .CORE_RESET);

/* testbench/pwrt_core_model.sv */
// Core-side model: counts wake requests and periodic resets.
// Assumes the timer drives its core outputs from the same clock.
`timescale 1ns/1ps
module pwrt_core_model (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset,
  // Timer outputs.
  input  wire logic wake_in,
  input  wire logic core_rst_in,
  // Counts for the bench.
  output logic [7:0] wakes,
  output logic [7:0] resets
);
  logic wake_d; // Last wake level, so a held level counts once.
  // The core has no mask: every new wake level is taken.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wake_d <= 1'b0;
      wakes  <= 8'h00;
      resets <= 8'h00;
    end else begin
      wake_d <= wake_in;
      if (wake_in && !wake_d) wakes <= wakes + 8'h01;
      if (core_rst_in) resets <= resets + 8'h01;
    end
  end
endmodule : pwrt_core_model

/* testbench/tb.sv */
// Self-checking bench for the periodic wake and reset timer.
// Assumes the timer answers APB itself and the tick pin runs free.
`timescale 1ns/1ps
module tb;
  logic        clock = 1'b0;    // 200 MHz clock.
  logic        reset = 1'b1;    // Power-on reset.
  logic [1:0]  tick_div = 2'h0; // Tick pin is bit 1: four cycles a tick.
  logic        oor = 1'b0;      // Thermal out-of-range pin.
  logic        warm = 1'b0;     // Warm reset pin.
  logic        psel = 1'b0;     // APB select.
  logic        pen = 1'b0;      // APB enable.
  logic        pwr = 1'b0;      // APB direction.
  logic [31:0] paddr = 32'h0;   // APB address.
  logic [31:0] pwdata = 32'h0;  // APB write data.
  logic        pready, perr, wake, crst, irq; // Timer outputs.
  logic [31:0] prdata;          // Read data.
  logic        err_last;        // Error flag of the last access.
  logic [7:0]  wakes, resets;   // Counts seen by the core model.
  int          err_count = 0;   // Mismatches.
  int          comparisons = 0; // Comparisons made.
  time         t0;              // Time of a wake.
  always #2.5 clock = ~clock;
  // The tick never stops, even in reset: the timer is always on.
  always @(posedge clock) tick_div <= tick_div + 2'h1;
  pwrt_top pwrt_top_inst (.CLOCK(clock), .RESET(reset), .LFO_TICK(tick_div[1]), .THERMAL_OUT_OF_RANGE(oor),
    .WARM_RESET(warm), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(perr), .WAKE_INTERRUPT(wake), .CORE_RESET(crst), .IRQ(irq));
  pwrt_core_model pwrt_core_model_inst (.clock(clock), .reset(reset), .wake_in(wake), .core_rst_in(crst),
    .wakes(wakes), .resets(resets));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; a read compares the masked data.
  task automatic acc(input logic w, input logic [31:0] a, d, m, e);
    @(posedge clock);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    pen <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    err_last = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (!w) chk(prdata & m, e);
  endtask : acc
  task automatic wait_hi(input logic r);
    do @(posedge clock); while ((r ? crst : wake) !== 1'b1);
  endtask : wait_hi
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  // Watchdog: the whole run needs about 15000 cycles.
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    acc(1'b0, 32'hE0, '0, 32'hFF, 32'h1F);
    acc(1'b0, 32'hE4, '0, 32'hFF, 32'h3F);
    acc(1'b0, 32'h100, '0, '0, '0);
    chk({31'h0, err_last}, 32'h1);
    acc(1'b1, 32'hE0, 32'hFF, '0, '0);
    acc(1'b0, 32'hE0, '0, 32'hFF, 32'h3F);
    acc(1'b1, 32'hE8, '0, '0, '0);
    acc(1'b1, 32'hE4, '0, '0, '0);
    acc(1'b0, 32'hE4, '0, 32'h3F, 32'h3F);
    $display("test registers done");
    acc(1'b1, 32'hE0, 32'h1, '0, '0);
    acc(1'b1, 32'hFC, 32'h1, '0, '0);
    acc(1'b1, 32'hE4, 32'h1, '0, '0);
    wait_hi(1'b0);
    t0 = $time;
    acc(1'b0, 32'hEC, '0, 32'h3F00, '0);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, 32'hE4, 32'h01, '0, '0);
    chk({31'h0, wake}, 32'h1);
    acc(1'b1, 32'hE4, 32'h41, '0, '0);
    repeat (2) @(posedge clock);
    chk({31'h0, wake}, 32'h0);
    wait_hi(1'b0);
    // Prescale 1, four cycles a tick, 5 ns a cycle; the same-value write must not restart.
    chk(32'($time - t0), 32'((504 + 16) * 4 * 5));
    acc(1'b1, 32'hFC, '0, '0, '0);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, 32'hF8, 32'h7, '0, '0);
    acc(1'b0, 32'hF4, '0, 32'h7, '0);
    acc(1'b1, 32'hE4, 32'h41, '0, '0);
    $display("test wake done");
    acc(1'b1, 32'hE8, 32'h2, '0, '0);
    wait_hi(1'b0);
    acc(1'b1, 32'hE4, 32'h41, '0, '0);
    acc(1'b1, 32'hF8, 32'h7, '0, '0);
    wait_hi(1'b1);
    repeat (2) @(posedge clock);
    chk({24'h0, resets}, 32'h1);
    chk({24'h0, wakes}, 32'h3);
    acc(1'b0, 32'hF4, '0, 32'h3, 32'h2);
    acc(1'b1, 32'hEC, 32'h1, '0, '0);
    acc(1'b0, 32'hEC, '0, 32'h3F00, '0);
    wait_hi(1'b0);
    acc(1'b0, 32'hEC, '0, 32'h3F00, 32'h100);
    acc(1'b1, 32'hEC, '0, '0, '0);
    acc(1'b0, 32'hEC, '0, 32'h3F00, '0);
    acc(1'b1, 32'hE4, 32'h41, '0, '0);
    $display("test reset done");
    acc(1'b1, 32'hF0, 32'h1, '0, '0);
    oor <= 1'b1;
    repeat (4400) @(posedge clock);
    chk({24'h0, wakes}, 32'h4);
    chk({24'h0, resets}, 32'h1);
    acc(1'b0, 32'hF4, '0, 32'h4, 32'h4);
    acc(1'b0, 32'hF0, '0, 32'h3, 32'h3);
    oor <= 1'b0;
    acc(1'b1, 32'hE0, 32'h5, '0, '0);
    warm <= 1'b1;
    repeat (4) @(posedge clock);
    warm <= 1'b0;
    repeat (4) @(posedge clock);
    acc(1'b0, 32'hE0, '0, 32'hFF, 32'h5);
    acc(1'b0, 32'hE4, '0, 32'hFF, 32'h3F);
    $display("test thermal and warm reset done");
    conclude();
  end
endmodule : tb
